// >>> core/acc_adc_ctrl.sv
// converter control: sfr pair, clock divider, triggers and sequencer
`timescale 1ns/1ps
`include "acc_defines.svh"

// How it works
// R1 - power output follows the power-on bit of the timing register
// R2 - reference select output follows the external reference bit
// R3 - converter clock is master clock divided by 8, 4, 16 or 32
// R4 - software keeps converter clock at or below 4.5 MHz
// R5 - conversion phase lasts 17 converter clocks after acquisition
// R6 - acquisition lasts 1 to 4 converter clocks by its field
// R7 - software should pick at least three acquisition clocks
// R8 - timer 2 overflow starts a conversion when its enable is set
// R9 - falling external strobe starts a conversion when enabled
// R10 - done flag is set when a conversion cycle completes
// R11 - done flag clears when the processor vectors to the handler
// R12 - software clears the done flag when not vectoring
// R13 - setting the dma bit requests the configured capture
// R14 - dma bit clears itself when the capture cycle finishes
// R15 - address latch strobe is held off from dma set until dma start
// R16 - continuous bit restarts a conversion after each one ends
// R17 - each continuous conversion uses the programmed settings
// R18 - writing one to single bit runs exactly one conversion
// R19 - both control registers reset to 00h
// R20 - mode register takes bit writes, timing register bytes only
// R21 - software start samples the four-bit channel field
// R22 - channel number goes in top nibble of high result byte
// R23 - all triggers are ignored while the converter is powered down
module acc_adc_ctrl
    import acc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_bit_wr,
    input  wire logic [2:0]  sfr_bit_idx,
    input  wire logic        sfr_bit_val,
    input  wire logic        sfr_rd,
    output logic      [7:0]  sfr_rdata,
    input  wire logic        timer2_overflow,
    input  wire logic        external_convert_strobe_n,
    input  wire logic        isr_vector_ack,
    input  wire logic        dma_capture_start,
    input  wire logic        dma_capture_done,
    input  wire logic [11:0] sar_result,
    output logic             converter_power_on,
    output logic             ext_ref_sel,
    output logic             adc_clk,
    output logic             track_hold,
    output logic             sar_convert,
    output logic      [3:0]  sar_channel,
    output logic             dma_enable,
    output logic             ale_stop,
    output logic      [7:0]  result_high_byte,
    output logic      [7:0]  result_low_byte
);
    logic [7:0]  mode_reg;
    logic [7:0]  mode_next;
    logic [7:0]  timing_reg;
    logic [7:0]  timing_next;
    logic [4:0]  div_cnt_reg;
    logic [4:0]  phase_cnt_reg;
    logic [4:0]  phase_cnt_next;
    logic        strobe_s1_reg;
    logic        strobe_s2_reg;
    logic        strobe_s3_reg;
    logic        dma_active_reg;
    logic        dma_active_next;
    acc_state_e  state_reg;
    acc_state_e  state_next;

    // sfr decode
    wire        mode_sel    = (sfr_addr == `ACC_MODE_ADDR);
    wire        timing_sel  = (sfr_addr == `ACC_TIMING_ADDR);
    wire        mode_byte   = sfr_wr && mode_sel;
    wire        mode_bit    = sfr_bit_wr && mode_sel; // R20
    wire        mode_wr     = mode_byte || mode_bit;
    wire        timing_wr   = sfr_wr && timing_sel; // R20
    wire [7:0]  bit_mask    = 8'h01 << sfr_bit_idx;
    wire [7:0]  bit_value   = sfr_bit_val ? (mode_reg | bit_mask)
                                          : (mode_reg & ~bit_mask);
    wire [7:0]  mode_wv     = mode_byte ? sfr_wdata
                            : mode_bit  ? bit_value : mode_reg;
    wire [7:0]  read_value  = mode_sel   ? mode_reg
                            : timing_sel ? timing_reg : 8'h00;

    // timing register fields
    wire        pwr_on      = timing_reg[`ACC_PWR_BIT];
    wire [1:0]  ck_sel      = timing_reg[5:4];
    wire [1:0]  aq_sel      = timing_reg[3:2];
    wire        t2c_en      = timing_reg[`ACC_T2C_BIT];
    wire        exc_en      = timing_reg[`ACC_EXC_BIT];

    // divider end count per code; the odd order of codes is intended
    wire [4:0]  div_last    = (ck_sel == 2'b00) ? `ACC_DIV_LAST_00
                            : (ck_sel == 2'b01) ? `ACC_DIV_LAST_01
                            : (ck_sel == 2'b10) ? `ACC_DIV_LAST_10
                            : `ACC_DIV_LAST_11; // R3
    wire        adc_tick    = (div_cnt_reg >= div_last);
    wire [4:0]  div_half    = 5'((div_last + 5'h01) >> 1);

    // trigger sources; strobe is a pin, so only s2/s3 feed logic
    wire        strobe_fall = strobe_s3_reg && !strobe_s2_reg;
    wire        sw_start    = mode_reg[`ACC_SINGLE_CONVERSION_BIT]; // R18 R21
    wire        cont_start  = mode_reg[`ACC_CONTINUOUS_CONVERSION_BIT]; // R16 R17
    wire        t2_start    = t2c_en && timer2_overflow; // R8
    wire        ext_start   = exc_en && strobe_fall; // R9
    wire        any_start   = sw_start || cont_start
                           || t2_start || ext_start;
    wire        idle        = (state_reg == ACC_IDLE);
    wire        go          = pwr_on && idle && any_start; // R23
    wire        acq_end     = (state_reg == ACC_ACQUIRE) && adc_tick
                           && (phase_cnt_reg == {3'b000, aq_sel}); // R6
    wire        conv_end    = (state_reg == ACC_CONVERT) && adc_tick
                           && (phase_cnt_reg == `ACC_CONV_LAST); // R5
    wire        done_evt    = (state_reg == ACC_DONE);

    // sequencer next state; power-down aborts any conversion
    always_comb begin
        state_next     = state_reg;
        phase_cnt_next = phase_cnt_reg;
        case (state_reg)
            ACC_IDLE: begin
                phase_cnt_next = 5'h00;
                if (go) begin
                    state_next = ACC_ACQUIRE;
                end
            end
            ACC_ACQUIRE: begin
                if (acq_end) begin
                    state_next     = ACC_CONVERT; // R6
                    phase_cnt_next = 5'h00;
                end else if (adc_tick) begin
                    phase_cnt_next = phase_cnt_reg + 5'h01;
                end
            end
            ACC_CONVERT: begin
                if (conv_end) begin
                    state_next = ACC_DONE; // R5
                end else if (adc_tick) begin
                    phase_cnt_next = phase_cnt_reg + 5'h01;
                end
            end
            ACC_DONE: begin
                state_next = ACC_IDLE; // R16
            end
            default: begin
                state_next = ACC_IDLE;
            end
        endcase
        if (!pwr_on) begin
            state_next = ACC_IDLE; // R1 R23
        end
    end

    // mode register: software writes, hardware set wins over clear
    always_comb begin
        mode_next = mode_wv;
        mode_next[`ACC_FLAG_BIT] = done_evt
            || (mode_wv[`ACC_FLAG_BIT] && !isr_vector_ack); // R10 R11
        if (!mode_wr && dma_capture_done) begin
            mode_next[`ACC_DMA_BIT] = 1'b0; // R14
        end
        if (!mode_wr && done_evt) begin
            mode_next[`ACC_SINGLE_CONVERSION_BIT] = 1'b0; // R18
        end
    end

    assign timing_next = timing_wr ? sfr_wdata : timing_reg;

    // dma tracking: active from capture start until it finishes
    assign dma_active_next = dma_capture_start
        || (dma_active_reg && !dma_capture_done);

    // control registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_reg   <= `ACC_MODE_RESET; // R19
            timing_reg <= `ACC_TIMING_RESET; // R19
        end else begin
            mode_reg   <= mode_next; // R20
            timing_reg <= timing_next;
        end
    end

    // sfr read data, registered
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= read_value;
        end
    end

    // converter clock divider, free running from the master clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_cnt_reg <= 5'h00;
            adc_clk     <= 1'b0;
        end else begin
            div_cnt_reg <= adc_tick ? 5'h00 : div_cnt_reg + 5'h01; // R3
            adc_clk     <= adc_tick || (div_cnt_reg + 5'h01 < div_half);
        end
    end

    // strobe synchroniser plus one stage for the edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strobe_s1_reg <= 1'b1;
            strobe_s2_reg <= 1'b1;
            strobe_s3_reg <= 1'b1;
        end else begin
            strobe_s1_reg <= external_convert_strobe_n;
            strobe_s2_reg <= strobe_s1_reg;
            strobe_s3_reg <= strobe_s2_reg;
        end
    end

    // sequencer state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg     <= ACC_IDLE;
            phase_cnt_reg <= 5'h00;
        end else begin
            state_reg     <= state_next;
            phase_cnt_reg <= phase_cnt_next;
        end
    end

    // channel latched at start so a mid-conversion write cannot skew it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sar_channel <= 4'h0;
        end else if (go) begin
            sar_channel <= mode_reg[3:0]; // R21 R17
        end
    end

    // result capture with channel tag in the top nibble
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            result_high_byte <= `ACC_RESULT_RESET;
            result_low_byte  <= `ACC_RESULT_RESET;
        end else if (conv_end) begin
            result_high_byte <= {sar_channel, sar_result[11:8]}; // R22
            result_low_byte  <= sar_result[7:0];
        end
    end

    // analog side controls, all from flops
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            converter_power_on <= 1'b0;
            ext_ref_sel        <= 1'b0;
            track_hold         <= 1'b0;
            sar_convert        <= 1'b0;
            dma_enable         <= 1'b0;
            ale_stop           <= 1'b0;
            dma_active_reg     <= 1'b0;
        end else begin
            converter_power_on <= timing_next[`ACC_PWR_BIT]; // R1
            ext_ref_sel        <= timing_next[`ACC_EXTREF_BIT]; // R2
            track_hold         <= (state_next == ACC_ACQUIRE);
            sar_convert        <= (state_next == ACC_CONVERT);
            dma_enable         <= mode_next[`ACC_DMA_BIT]; // R13
            ale_stop           <= mode_next[`ACC_DMA_BIT]
                               && !dma_active_next; // R15
            dma_active_reg     <= dma_active_next;
        end
    end

    AST_PWR_IDLE: assert property (@(posedge ref_clk) disable iff (rst) // R23
        !pwr_on |=> idle)
        else $error("converter not idle while powered down");
    AST_DIV_BY4: assert property (@(posedge ref_clk) // R3
        disable iff (rst || timing_wr)
        (adc_tick && ck_sel == 2'b01) |=> !adc_tick [*3] ##1 adc_tick)
        else $error("divide by four tick spacing wrong");
    // a power-down on the last tick aborts instead of finishing
    AST_CONV_LEN: assert property (@(posedge ref_clk) disable iff (rst) // R5
        (conv_end && pwr_on) |-> phase_cnt_reg == 5'h10
        ##1 state_reg == ACC_DONE)
        else $error("conversion phase not seventeen clocks");
    AST_ACQ_LEN: assert property (@(posedge ref_clk) disable iff (rst) // R6
        (acq_end && pwr_on) |=> state_reg == ACC_CONVERT
        && phase_cnt_reg == 5'h00)
        else $error("acquisition did not end into conversion");
    AST_EXT_START: assert property (@(posedge ref_clk) disable iff (rst) // R9
        (ext_start && pwr_on && idle) |=> state_reg == ACC_ACQUIRE)
        else $error("external strobe did not start conversion");
    AST_FLAG_SET: assert property (@(posedge ref_clk) disable iff (rst) // R10
        done_evt |=> mode_reg[`ACC_FLAG_BIT])
        else $error("done flag not set at end of conversion");
    AST_FLAG_CLR: assert property (@(posedge ref_clk) disable iff (rst) // R11
        (isr_vector_ack && !done_evt && !mode_wr)
        |=> !mode_reg[`ACC_FLAG_BIT])
        else $error("done flag not cleared on vector");
    AST_DMA_CLR: assert property (@(posedge ref_clk) disable iff (rst) // R14
        (dma_capture_done && !mode_wr) |=> !dma_enable
        && !mode_reg[`ACC_DMA_BIT])
        else $error("dma bit not cleared at capture end");
    AST_ALE_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // R15
        dma_capture_start |=> !ale_stop)
        else $error("address latch still held off after dma start");
    AST_ALE_SET: assert property (@(posedge ref_clk) disable iff (rst) // R15
        (mode_wr && mode_wv[`ACC_DMA_BIT] && !dma_capture_start
        && !dma_active_reg) |=> ale_stop)
        else $error("address latch not held off when dma bit set");
    AST_SINGLE: assert property (@(posedge ref_clk) disable iff (rst) // R18
        (done_evt && !mode_wr) |=> !mode_reg[`ACC_SINGLE_CONVERSION_BIT])
        else $error("single bit not cleared after one conversion");

    COV_SINGLE: cover property (@(posedge ref_clk) disable iff (rst)
        sw_start && go ##[1:1000] done_evt);
    COV_CONT: cover property (@(posedge ref_clk) disable iff (rst)
        cont_start && done_evt ##2 state_reg == ACC_ACQUIRE);
    COV_TIMER: cover property (@(posedge ref_clk) disable iff (rst)
        t2_start && go);
    COV_DMA: cover property (@(posedge ref_clk) disable iff (rst)
        ale_stop ##[1:100] !ale_stop && dma_enable);
endmodule : acc_adc_ctrl

// >>> core/acc_defines.svh
// register map, field positions, reset values and timing counts
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
`define ACC_MODE_ADDR     8'hd8
`define ACC_TIMING_ADDR   8'hef
`define ACC_MODE_RESET    8'h00
`define ACC_TIMING_RESET  8'h00
`define ACC_RESULT_RESET  8'h00
`define ACC_FLAG_BIT      7
`define ACC_DMA_BIT       6
`define ACC_CONTINUOUS_CONVERSION_BIT     5
`define ACC_SINGLE_CONVERSION_BIT     4
`define ACC_PWR_BIT       7
`define ACC_EXTREF_BIT    6
`define ACC_T2C_BIT       1
`define ACC_EXC_BIT       0
`define ACC_DIV_LAST_00   5'h07
`define ACC_DIV_LAST_01   5'h03
`define ACC_DIV_LAST_10   5'h0f
`define ACC_DIV_LAST_11   5'h1f
`define ACC_CONV_LAST     5'h10
`endif

// >>> core/acc_pkg.sv
// types shared by the converter control block
package acc_pkg;
    typedef enum logic [1:0] {
        ACC_IDLE    = 2'b00,
        ACC_ACQUIRE = 2'b01,
        ACC_CONVERT = 2'b11,
        ACC_DONE    = 2'b10
    } acc_state_e;
endpackage : acc_pkg

// >>> test/acc_sar_model.sv
// behavioural far side: converter core answer and dma capture engine
`timescale 1ns/1ps
module acc_sar_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        sar_convert,
    input  wire logic        ale_stop,
    input  wire logic [11:0] sar_value,
    output logic      [11:0] sar_result,
    output logic             dma_capture_start,
    output logic             dma_capture_done
);
    logic [11:0] junk_reg;
    logic [3:0]  dma_cnt_reg;
    wire         dma_last = (dma_cnt_reg == 4'hc);
    // outside a conversion the lines churn so a stale sample never matches
    assign sar_result = sar_convert ? sar_value : junk_reg;
    // capture begins a few cycles after the latch strobe is held off
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            junk_reg          <= 12'h5a5;
            dma_cnt_reg       <= 4'h0;
            dma_capture_start <= 1'b0;
            dma_capture_done  <= 1'b0;
        end else begin
            junk_reg          <= ~junk_reg;
            dma_capture_start <= (dma_cnt_reg == 4'h4);
            dma_capture_done  <= dma_last;
            if (ale_stop || dma_cnt_reg != 4'h0) begin
                dma_cnt_reg <= dma_last ? 4'h0 : dma_cnt_reg + 4'h1;
            end
        end
    end
endmodule : acc_sar_model

// >>> test/tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        sfr_bit_wr = 1'b0;
    logic [2:0]  sfr_bit_idx = 3'h0;
    logic        sfr_bit_val = 1'b0;
    logic        sfr_rd = 1'b0;
    logic        timer2_overflow = 1'b0;
    logic        external_convert_strobe_n = 1'b1;
    logic        isr_vector_ack = 1'b0;
    logic [11:0] sar_value = 12'h000;
    logic [11:0] sar_result;
    logic [7:0]  sfr_rdata, result_high_byte, result_low_byte;
    logic [3:0]  sar_channel, ch;
    logic        dma_capture_start, dma_capture_done, converter_power_on;
    logic        ext_ref_sel, adc_clk, track_hold, sar_convert;
    logic        dma_enable, ale_stop, rd_seen = 1'b0;
    logic [7:0]  exp_q [$];
    int          n_fail = 0, n_checks = 0, cycles = 0;
    int          divs [4] = '{8, 4, 16, 32};
    integer      seed = 32'hc004ee53;

    acc_adc_ctrl i_acc_adc_ctrl (.ref_clk, .rst, .sfr_addr, .sfr_wr,
        .sfr_wdata, .sfr_bit_wr, .sfr_bit_idx, .sfr_bit_val, .sfr_rd,
        .sfr_rdata, .timer2_overflow, .external_convert_strobe_n,
        .isr_vector_ack, .dma_capture_start, .dma_capture_done, .sar_result,
        .converter_power_on, .ext_ref_sel, .adc_clk, .track_hold,
        .sar_convert, .sar_channel, .dma_enable, .ale_stop,
        .result_high_byte, .result_low_byte);
    acc_sar_model i_acc_sar_model (.ref_clk, .rst, .sar_convert, .ale_stop,
        .sar_value, .sar_result, .dma_capture_start, .dma_capture_done);

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // the trailing #1 lets the sampling edge land before anyone looks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge ref_clk);
        sfr_wr    <= 1'b0;
        #1;
    endtask : wr

    task automatic bw(input logic [7:0] a, input logic [2:0] i, input logic v);
        @(posedge ref_clk);
        sfr_addr    <= a;
        sfr_bit_idx <= i;
        sfr_bit_val <= v;
        sfr_bit_wr  <= 1'b1;
        @(posedge ref_clk);
        sfr_bit_wr  <= 1'b0;
        #1;
    endtask : bw

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk);
        sfr_rd   <= 1'b0;
        #1;
    endtask : rd

    // 0 timer pulse, 1 long strobe low pulse, 2 vector ack; the strobe is
    // let go by a side process so the task returns before the start
    task automatic kick(input int k);
        @(posedge ref_clk);
        timer2_overflow <= (k == 0);
        isr_vector_ack  <= (k == 2);
        if (k == 1) begin
            external_convert_strobe_n <= 1'b0;
            fork
                begin
                    repeat (22) @(posedge ref_clk);
                    external_convert_strobe_n <= 1'b1;
                end
            join_none
        end
        @(posedge ref_clk);
        timer2_overflow <= 1'b0;
        isr_vector_ack  <= 1'b0;
        #1;
    endtask : kick

    // sampled at mid-cycle, at least one look before the acquisition count;
    // acquisition may begin mid-tick, so only its upper bound is exact
    task automatic run_conv(input int d, input int a);
        int n, th, sc;
        n = 0;
        th = 0;
        sc = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (track_hold !== 1'b1 && n < 300);
        while (track_hold === 1'b1 && th < 300) begin
            @(negedge ref_clk);
            th++;
        end
        while (sar_convert === 1'b1 && sc < 900) begin
            @(negedge ref_clk);
            sc++;
        end
        check(16'(th > a * d && th <= (a + 1) * d), 16'h1);
        check(16'(sc), 16'(17 * d));
    endtask : run_conv

    task automatic no_conv();
        int h;
        h = 0;
        repeat (60) begin
            @(posedge ref_clk);
            if (track_hold !== 1'b0) begin
                h++;
            end
        end
        check(16'(h), 16'h0);
    endtask : no_conv

    // skip two periods so a divider change mid-count has settled
    task automatic meas_div(input int d);
        realtime t0;
        repeat (2) @(posedge adc_clk);
        t0 = $realtime;
        @(posedge adc_clk);
        check(16'(int'(($realtime - t0) / 5.0)), 16'(d));
    endtask : meas_div

    // read data settles one cycle after the strobe; compare at mid-cycle
    always @(posedge ref_clk) rd_seen <= sfr_rd;
    always @(negedge ref_clk) begin
        if (rd_seen) begin
            check(16'(sfr_rdata), 16'(exp_q.pop_front()));
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'hd8, 8'h00);
        rd(8'hef, 8'h00);
        rd(8'h55, 8'h00);
        bw(8'hef, 3'h7, 1'b1);
        rd(8'hef, 8'h00);
        check(16'(converter_power_on), 16'h0);
        // the fast bench master leaves every code above the clock ceiling
        for (int c = 0; c < 4; c++) begin
            wr(8'hef, 8'(8'h80 | (c << 4)));
            meas_div(divs[c]);
        end
        for (int a = 0; a < 4; a++) begin
            ch = 4'($random(seed));
            @(posedge ref_clk);
            sar_value <= 12'($random(seed));
            wr(8'hef, {1'b1, a[0], 2'b01, a[1:0], 2'b00});
            check(16'(converter_power_on), 16'h1);
            check(16'(ext_ref_sel), 16'(a[0]));
            wr(8'hd8, {4'h1, ch});
            run_conv(4, a);
            repeat (3) @(posedge ref_clk);
            check(16'(result_high_byte), 16'({ch, sar_value[11:8]}));
            check(16'(result_low_byte), 16'(sar_value[7:0]));
            check(16'(sar_channel), 16'(ch));
            rd(8'hd8, {4'h8, ch});
            kick(2);
            rd(8'hd8, {4'h0, ch});
        end
        // triggers while powered down must be dropped
        wr(8'hd8, 8'h00);
        wr(8'hef, 8'h13);
        kick(0);
        kick(1);
        wr(8'hd8, 8'h10);
        no_conv();
        wr(8'hd8, 8'h00);
        wr(8'hef, 8'h93);
        kick(0);
        run_conv(4, 0);
        kick(1);
        run_conv(4, 0);
        wr(8'hef, 8'h90);
        kick(0);
        kick(1);
        no_conv();
        wr(8'hef, 8'h9c);
        bw(8'hd8, 3'h5, 1'b1);
        run_conv(4, 3);
        run_conv(4, 3);
        bw(8'hd8, 3'h5, 1'b0);
        repeat (120) @(posedge ref_clk);
        no_conv();
        wr(8'hd8, 8'h00);
        bw(8'hd8, 3'h6, 1'b1);
        repeat (2) @(posedge ref_clk);
        check(16'({dma_enable, ale_stop}), 16'h3);
        repeat (20) @(posedge ref_clk);
        check(16'({dma_enable, ale_stop}), 16'h0);
        rd(8'hd8, 8'h00);
        conclude();
    end
endmodule : tb
